// file: rtl/sfpo_port_select.sv
// Purpose: fast special-function path and hub path to the I/O port outputs
// Assumes: requests last one cycle; pins sampled synchronous to clock
// Notes:   read data lags one cycle behind its cause, pin outputs two cycles
//          pin-state reads sample the pads at the request edge
`timescale 1ns/100ps

// Overview of operation
// - ports 0-6, 12 and 15 each get value, owner and pin-level registers
// - writing the fast value register stores the requested pin output states
// - owner bit set: pin y driven from fast value bit y
// - owner bit clear: pin y follows hub-side value bit y of that port
// - pin-level register is read-only, returns pin levels, writes ignored
// - fast path reaches fast value, owner and level; hub reaches hub-side value, owner and level
// - hub port registers decode inside 0x005000 to 0x0051ff
module sfpo_port_select
  import sfpo_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  // special-function bus from the cpu core
  input  wire sfpo_sfr_req_t        sfr_req,
  output logic [7:0]                sfr_rdata,
  output logic                      sfr_hit,
  // peripheral hub bus
  input  wire sfpo_hub_req_t        hub_req,
  output logic [7:0]                hub_rdata,
  output logic                      hub_hit,
  // port pins
  input  wire logic [NUM_PORTS-1:0][PIN_COUNT-1:0] pin_level,
  output logic [NUM_PORTS-1:0][PIN_COUNT-1:0]      pin_out
);

  // register state, one byte per channel
  logic [NUM_PORTS-1:0][7:0] fast_port_output_value;
  logic [NUM_PORTS-1:0][7:0] fast_port_output_owner;
  logic [NUM_PORTS-1:0][7:0] hub_port_output_value;

  // per-channel read terms and address matches
  logic [NUM_PORTS-1:0][7:0] sfr_read_term;
  logic [NUM_PORTS-1:0][7:0] hub_read_term;
  logic [NUM_PORTS-1:0]      sfr_sel;
  logic [NUM_PORTS-1:0]      hub_sel;

  // merged read data and bus qualifiers
  logic [7:0]                next_sfr_rdata;
  logic [7:0]                next_hub_rdata;
  logic                      sfr_access;
  logic                      hub_access;
  logic                      hub_in_window;

  // a write is an access too, so hit also pulses for writes
  assign sfr_access = sfr_req.rd || sfr_req.wr;
  assign hub_access = hub_req.rd || hub_req.wr;

  // every mapped port sits inside the window today; the test keeps a
  // wider stride or a new port number from answering outside it
  assign hub_in_window = (hub_req.addr >= HUB_BASE_ADDR) &&
                         (hub_req.addr <= HUB_LAST_ADDR);

  genvar ch;
  generate
    for (ch = 0; ch < NUM_PORTS; ch++) begin : g_port
      // decoded addresses, matches and write strobes
      logic [23:0] port_base;
      logic [23:0] hub_value_addr;
      logic [23:0] hub_owner_addr;
      logic [23:0] hub_level_addr;
      logic        sfr_value_hit;
      logic        sfr_owner_hit;
      logic        sfr_level_hit;
      logic        hub_value_hit;
      logic        hub_owner_hit;
      logic        hub_level_hit;

      logic        sfr_value_wr;
      logic        sfr_owner_wr;
      logic        hub_value_wr;
      logic        hub_owner_wr;

      assign port_base      = HUB_BASE_ADDR + 24'(PORT_NUMBER[ch]) * HUB_PORT_STRIDE;
      assign hub_value_addr = port_base + 24'(HUB_VALUE_OFS);
      assign hub_owner_addr = port_base + 24'(HUB_OWNER_OFS);
      assign hub_level_addr = port_base + 24'(HUB_LEVEL_OFS);

      assign sfr_value_hit = (sfr_req.addr == SFR_VALUE_ADDR[ch]);
      assign sfr_owner_hit = (sfr_req.addr == SFR_OWNER_ADDR[ch]);
      assign sfr_level_hit = (sfr_req.addr == SFR_LEVEL_ADDR[ch]);
      assign hub_value_hit = hub_in_window && (hub_req.addr == hub_value_addr);
      assign hub_owner_hit = hub_in_window && (hub_req.addr == hub_owner_addr);
      assign hub_level_hit = hub_in_window && (hub_req.addr == hub_level_addr);

      assign sfr_sel[ch] = sfr_value_hit || sfr_owner_hit || sfr_level_hit;
      assign hub_sel[ch] = hub_value_hit || hub_owner_hit || hub_level_hit;

      // level addresses get no write strobe, so writes there change nothing
      assign sfr_value_wr = sfr_req.wr && sfr_value_hit;
      assign sfr_owner_wr = sfr_req.wr && sfr_owner_hit;
      assign hub_value_wr = hub_req.wr && hub_value_hit;
      assign hub_owner_wr = hub_req.wr && hub_owner_hit;

      // fast value: written only over the special-function bus
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          fast_port_output_value[ch] <= VALUE_RESET;
        end else if (sfr_value_wr) begin
          fast_port_output_value[ch] <= sfr_req.wdata;
        end
      end

      // owner reachable from both sides; fast side wins a same-cycle clash
      // a hub owner write lost in such a clash is not flagged anywhere
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          fast_port_output_owner[ch] <= OWNER_RESET;
        end else if (sfr_owner_wr) begin
          fast_port_output_owner[ch] <= sfr_req.wdata;
        end else if (hub_owner_wr) begin
          fast_port_output_owner[ch] <= hub_req.wdata;
        end
      end

      // hub-side value, only the hub can write it
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          hub_port_output_value[ch] <= VALUE_RESET;
        end else if (hub_value_wr) begin
          hub_port_output_value[ch] <= hub_req.wdata;
        end
      end

      // per-pin steering, registered so outputs come from flops
      // pins move two cycles after the write; the flop keeps them glitch-free
      for (genvar y = 0; y < PIN_COUNT; y++) begin : g_pin
        always_ff @(posedge clock) begin
          if (!reset_n) begin
            pin_out[ch][y] <= 1'b0;
          end else if (fast_port_output_owner[ch][y]) begin
            pin_out[ch][y] <= fast_port_output_value[ch][y];
          end else begin
            pin_out[ch][y] <= hub_port_output_value[ch][y];
          end
        end
      end

      // level register has no write path at all
      always_comb begin
        sfr_read_term[ch] = READ_IDLE;
        if (sfr_value_hit) begin
          sfr_read_term[ch] = fast_port_output_value[ch];
        end else if (sfr_owner_hit) begin
          sfr_read_term[ch] = fast_port_output_owner[ch];
        end else if (sfr_level_hit) begin
          sfr_read_term[ch] = pin_level[ch];
        end
      end

      always_comb begin
        hub_read_term[ch] = READ_IDLE;
        if (hub_value_hit) begin
          hub_read_term[ch] = hub_port_output_value[ch];
        end else if (hub_owner_hit) begin
          hub_read_term[ch] = fast_port_output_owner[ch];
        end else if (hub_level_hit) begin
          hub_read_term[ch] = pin_level[ch];
        end
      end
    end
  endgenerate

  // addresses are unique, so an or of the per-port terms is the mux
  // zero is the idle term, so unmapped reads fall out as zero
  always_comb begin
    next_sfr_rdata = READ_IDLE;
    for (int i = 0; i < NUM_PORTS; i++) begin
      next_sfr_rdata = next_sfr_rdata | sfr_read_term[i];
    end
  end

  always_comb begin
    next_hub_rdata = READ_IDLE;
    for (int i = 0; i < NUM_PORTS; i++) begin
      next_hub_rdata = next_hub_rdata | hub_read_term[i];
    end
  end

  // read answers; unmapped addresses give zero and no hit
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sfr_rdata <= READ_IDLE;
    end else begin
      sfr_rdata <= sfr_req.rd ? next_sfr_rdata : READ_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sfr_hit <= 1'b0;
    end else begin
      sfr_hit <= sfr_access && (|sfr_sel);
    end
  end

  // hub answers keep the same one-cycle timing as the fast path
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hub_rdata <= READ_IDLE;
    end else begin
      hub_rdata <= hub_req.rd ? next_hub_rdata : READ_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hub_hit <= 1'b0;
    end else begin
      hub_hit <= hub_access && (|hub_sel);
    end
  end

endmodule : sfpo_port_select

// file: pkg/sfpo_pkg.sv
// Purpose: constants and carriers for the fast port output select block
// Assumes: 8-bit special-function bus and 24-bit hub bus, both on clock
// Notes:   channel order is ports 0,1,2,3,4,5,6,12,15
package sfpo_pkg;

  localparam int NUM_PORTS = 9;
  localparam int PIN_COUNT = 8;

  // port number behind each channel
  localparam logic [3:0] PORT_NUMBER [NUM_PORTS] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hc, 4'hf};

  // special-function addresses per channel
  localparam logic [7:0] SFR_VALUE_ADDR [NUM_PORTS] = '{
    8'h80, 8'h90, 8'h98, 8'hb0, 8'hc0, 8'hc8, 8'hd8, 8'he8, 8'hf8};
  localparam logic [7:0] SFR_LEVEL_ADDR [NUM_PORTS] = '{
    8'h89, 8'h91, 8'h99, 8'hb1, 8'hc1, 8'hc9, 8'hd9, 8'he9, 8'hf9};
  localparam logic [7:0] SFR_OWNER_ADDR [NUM_PORTS] = '{
    8'h8a, 8'ha2, 8'h9a, 8'hb2, 8'hc2, 8'hca, 8'hda, 8'hf2, 8'hfa};

  // hub window for port control
  localparam logic [23:0] HUB_BASE_ADDR  = 24'h005000;
  localparam logic [23:0] HUB_LAST_ADDR  = 24'h0051ff;
  localparam logic [23:0] HUB_PORT_STRIDE = 24'h000010;
  localparam logic [3:0]  HUB_VALUE_OFS  = 4'h0;
  localparam logic [3:0]  HUB_OWNER_OFS  = 4'h1;
  localparam logic [3:0]  HUB_LEVEL_OFS  = 4'h2;

  // reset values
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [7:0] OWNER_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE   = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfpo_sfr_req_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } sfpo_hub_req_t;

endpackage : sfpo_pkg

// file: test/sfpo_monitor.sv
// Purpose: port-level checks for sfpo_port_select
// Assumes: one clock, synchronous active-low reset
// Notes:   channel 0 stands in for all channels
`timescale 1ns/100ps
module sfpo_monitor
  import sfpo_pkg::*;
(
  // clock and reset
  input wire logic                                clock,
  input wire logic                                reset_n,
  // buses
  input wire sfpo_sfr_req_t                       sfr_req,
  input wire logic [7:0]                          sfr_rdata,
  input wire logic                                sfr_hit,
  input wire sfpo_hub_req_t                       hub_req,
  input wire logic [7:0]                          hub_rdata,
  input wire logic                                hub_hit,
  // pins
  input wire logic [NUM_PORTS-1:0][PIN_COUNT-1:0] pin_level,
  input wire logic [NUM_PORTS-1:0][PIN_COUNT-1:0] pin_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_own(v);
    sfr_req.wr && sfr_req.addr == 8'h8a && sfr_req.wdata == v;
  endsequence
  sequence s_fast;
    sfr_req.wr && sfr_req.addr == 8'h80 && !hub_req.wr;
  endsequence
  sequence s_hub;
    hub_req.wr && hub_req.addr == 24'h005000 && !sfr_req.wr;
  endsequence
  a_fast_drive: assert property (
    s_own(8'hff) ##1 s_fast |=> ##1 pin_out[0] == $past(sfr_req.wdata, 2))
    else $error("fast data not on pins");
  a_hub_drive: assert property (
    s_own(8'h00) ##1 s_hub |=> ##1 pin_out[0] == $past(hub_req.wdata, 2))
    else $error("hub data not on pins");
  a_level_read: assert property (
    sfr_req.rd && sfr_req.addr == 8'h89 |=> sfr_hit && sfr_rdata == $past(pin_level[0]))
    else $error("pin level read wrong");
  a_sfr_unmapped: assert property (
    sfr_req.rd && sfr_req.addr == 8'h81 |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped fast address answered");
  a_idle_rdata: assert property (!sfr_req.rd |=> sfr_rdata == 8'h00)
    else $error("read data without read");
  a_hub_range: assert property (hub_hit |-> $past(hub_req.addr) >= 24'h005000
    && $past(hub_req.addr) <= 24'h0051ff) else $error("hub hit outside window");
  a_hub_outside: assert property (
    (hub_req.rd || hub_req.wr) && hub_req.addr > 24'h0051ff |=> !hub_hit && hub_rdata == 8'h00)
    else $error("hub answered outside window");
  a_reset_out: assert property (disable iff (1'b0) !reset_n |=> pin_out == '0)
    else $error("pins not cleared by reset");
endmodule : sfpo_monitor
bind sfpo_port_select sfpo_monitor sfpo_monitor_inst (.clock, .reset_n, .sfr_req, .sfr_rdata,
  .sfr_hit, .hub_req, .hub_rdata, .hub_hit, .pin_level, .pin_out);

// file: test/sfpo_pin_model.sv
// Purpose: port pins seen from the pads
// Assumes: a shorted pin reads inverted
// Notes:   level settles one clock after the buffer
`timescale 1ns/100ps
module sfpo_pin_model
  import sfpo_pkg::*;
(
  // clock
  input  wire logic                                clock,
  // buffers and fault mask
  input  wire logic [NUM_PORTS-1:0][PIN_COUNT-1:0] pin_out,
  input  wire logic [NUM_PORTS-1:0][PIN_COUNT-1:0] short_mask,
  // sensed levels
  output logic      [NUM_PORTS-1:0][PIN_COUNT-1:0] pin_level
);
  always_ff @(posedge clock) begin
    pin_level <= pin_out ^ short_mask;
  end
endmodule : sfpo_pin_model

// file: test/sfpo_port_select_bench.sv
// Purpose: self-checking bench for sfpo_port_select
// Assumes: answers one cycle after the request edge
// Notes:   levels come back through the pin model
`timescale 1ns/100ps
module sfpo_port_select_bench
  import sfpo_pkg::*;
;
  logic                                clock = 1'b0;
  logic                                reset_n = 1'b0;
  sfpo_sfr_req_t                       sfr_req = '0;
  sfpo_hub_req_t                       hub_req = '0;
  logic [7:0]                          sfr_rdata, hub_rdata;
  logic                                sfr_hit, hub_hit;
  logic [NUM_PORTS-1:0][PIN_COUNT-1:0] pin_level, pin_out, short_mask = '0;
  int                                  num_errors = 0;
  int                                  n_compared = 0;
  always #2 clock = ~clock;
  sfpo_port_select sfpo_port_select_inst (.clock, .reset_n, .sfr_req, .sfr_rdata, .sfr_hit,
    .hub_req, .hub_rdata, .hub_hit, .pin_level, .pin_out);
  sfpo_pin_model sfpo_pin_model_inst (.clock, .pin_out, .short_mask, .pin_level);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic put(input bit hub, input logic [23:0] a, input logic [7:0] d, input logic w);
    @(posedge clock);
    sfr_req <= '{a[7:0], d, w & !hub, 1'b0};
    hub_req <= '{a, d, w & hub, 1'b0};
  endtask : put
  task automatic probe(input bit hub, input logic [23:0] a, input logic [7:0] eq, input bit eh);
    @(posedge clock);
    sfr_req <= '{a[7:0], 8'h00, 1'b0, !hub};
    hub_req <= '{a, 8'h00, 1'b0, hub};
    put(1'b0, 24'h0, 8'h00, 1'b0);
    #1;
    check(hub ? hub_rdata : sfr_rdata, eq);
    check({7'h0, hub ? hub_hit : sfr_hit}, {7'h0, eh});
  endtask : probe
  task automatic settle;
    put(1'b0, 24'h0, 8'h00, 1'b0);
    @(posedge clock);
    #1;
  endtask : settle
  task automatic t_fast;
    for (int c = 0; c < NUM_PORTS; c++) begin
      probe(1'b0, {16'h0, SFR_OWNER_ADDR[c]}, 8'h00, 1'b1);
      put(1'b0, {16'h0, SFR_OWNER_ADDR[c]}, 8'hff, 1'b1);
      put(1'b0, {16'h0, SFR_VALUE_ADDR[c]}, 8'h5a ^ 8'(c), 1'b1);
      settle;
      check(pin_out[c], 8'h5a ^ 8'(c));
      probe(1'b0, {16'h0, SFR_VALUE_ADDR[c]}, 8'h5a ^ 8'(c), 1'b1);
    end
    $display("fast path test done");
  endtask : t_fast
  task automatic t_mixed;
    put(1'b0, 24'h00008a, 8'h00, 1'b1);
    put(1'b1, 24'h005000, 8'h3c, 1'b1);
    put(1'b0, 24'h000080, 8'hc3, 1'b1);
    put(1'b0, 24'h00008a, 8'h0f, 1'b1);
    settle;
    check(pin_out[0], 8'h33);
    probe(1'b1, 24'h005001, 8'h0f, 1'b1);
    probe(1'b1, 24'h005000, 8'h3c, 1'b1);
    put(1'b1, 24'h005001, 8'hf0, 1'b1);
    probe(1'b0, 24'h00008a, 8'hf0, 1'b1);
    // same-cycle owner writes from both buses: fast side keeps it
    @(posedge clock);
    sfr_req <= '{8'h8a, 8'h55, 1'b1, 1'b0};
    hub_req <= '{24'h005001, 8'haa, 1'b1, 1'b0};
    probe(1'b1, 24'h005001, 8'h55, 1'b1);
    put(1'b0, 24'h00008a, 8'h0f, 1'b1);
    $display("mixed owner test done");
  endtask : t_mixed
  task automatic t_level;
    @(posedge clock);
    short_mask[8] <= 8'h81;
    probe(1'b0, 24'h0000f9, 8'hd3, 1'b1);
    probe(1'b1, 24'h0050f2, 8'hd3, 1'b1);
    put(1'b0, 24'h0000f9, 8'hff, 1'b1);
    probe(1'b0, 24'h0000f9, 8'hd3, 1'b1);
    probe(1'b0, 24'h000089, 8'h33, 1'b1);
    $display("pin level test done");
  endtask : t_level
  task automatic t_map;
    probe(1'b0, 24'h000081, 8'h00, 1'b0);
    probe(1'b1, 24'h005200, 8'h00, 1'b0);
    probe(1'b1, 24'h004ff0, 8'h00, 1'b0);
    probe(1'b1, 24'h005071, 8'h00, 1'b0);
    $display("address map test done");
  endtask : t_map
  task automatic t_reset;
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    probe(1'b0, 24'h0000fa, 8'h00, 1'b1);
    probe(1'b1, 24'h005000, 8'h00, 1'b1);
    check(pin_out[8], 8'h00);
    $display("mid-run reset test done");
  endtask : t_reset
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    t_fast;
    t_mixed;
    t_level;
    t_map;
    t_reset;
    stop_test;
  end
  // whole run needs well under 400 cycles
  initial begin
    repeat (2000) @(posedge clock);
    num_errors++;
    stop_test;
  end
endmodule : sfpo_port_select_bench
